// [logic/fdc_pkg.sv]
// Operation
// RULE1: The fan duty cycle is an 8-bit value of about 0.39 percent per step spanning 0 to 100 percent, resetting near one third.
// RULE2: In direct-duty mode a duty register write changes the output duty at once, with no wait for a period end or a ramp.
// RULE3: Reading the duty register returns the duty that is driving the fan output, whatever mode produced it.
// RULE4: In direct-duty mode the written duty value becomes the value driving the fan output.
// RULE5: Outside direct-duty mode a duty write leaves the fan output alone and is kept in a holding store.
// RULE6: Switching into direct-duty mode drives the fan output from the holding store at once.
// RULE7: A ramp configuration register resets to 0x52 and holds a ramp enable, a 2-bit step, a 3-bit rate and a 2-bit threshold.
// RULE8: The local sensor mapping register resets to 0x41 with a 5-bit low-temperature point above a 3-bit slope.
// RULE9: The remote sensor mapping register resets to 0x61 with a 5-bit low-temperature point above a 3-bit slope.
// RULE10: In automatic temperature mode, at or below the low-temperature point, the output uses a low-temperature duty resetting to 0x55.
// RULE11: The holding store resets to the duty register reset value so a mode switch before any write applies the default duty.
package fdc_pkg;

  // Register offsets as seen through the serial management port.
  localparam logic [7:0] FDC_OFS_CONFIG   = 8'h00;
  localparam logic [7:0] FDC_OFS_LOW_DUTY = 8'h21;
  localparam logic [7:0] FDC_OFS_DUTY     = 8'h22;
  localparam logic [7:0] FDC_OFS_RAMP     = 8'h23;
  localparam logic [7:0] FDC_OFS_LOCAL    = 8'h24;
  localparam logic [7:0] FDC_OFS_REMOTE   = 8'h25;

  // Reset values.
  localparam logic [7:0] FDC_RST_CONFIG   = 8'h00;
  localparam logic [7:0] FDC_RST_DUTY     = 8'h55;
  localparam logic [7:0] FDC_RST_LOW_DUTY = 8'h55;
  localparam logic [7:0] FDC_RST_RAMP     = 8'h52;
  localparam logic [7:0] FDC_RST_LOCAL    = 8'h41;
  localparam logic [7:0] FDC_RST_REMOTE   = 8'h61;
  localparam logic [7:0] FDC_READ_UNMAPPED = 8'h00;

  // Field positions.
  localparam int FDC_MODE_LSB  = 0;
  localparam int FDC_RAMP_ON   = 7;
  localparam int FDC_STEP_LSB  = 5;
  localparam int FDC_RATE_LSB  = 2;
  localparam int FDC_THR_LSB   = 0;
  localparam int FDC_PT_LSB    = 3;
  localparam int FDC_SLOPE_LSB = 0;

  // Fan control modes held in the configuration register.
  localparam logic [1:0] FDC_MODE_AUTO   = 2'h0;
  localparam logic [1:0] FDC_MODE_RPM    = 2'h1;
  localparam logic [1:0] FDC_MODE_DIRECT = 2'h2;

  // The pulse-width period is 255 counts so that 0xff reads as full on.
  localparam logic [7:0] FDC_PWM_LAST = 8'hfe;
  localparam logic [7:0] FDC_DUTY_MAX = 8'hff;

  // Serial port constants.
  localparam logic [6:0] FDC_DEV_ADDR  = 7'h18;  // Arbitrary value.
  localparam logic [3:0] FDC_BITS_BYTE = 4'h8;
  localparam logic [3:0] FDC_BIT_LAST  = 4'h7;

  // Base ramp update interval; the rate field doubles it per step.
  localparam int FDC_RAMP_BASE_NS   = 1000000;
  localparam int FDC_CLK_PERIOD_NS  = 10;
  localparam int FDC_RAMP_BASE_CYC  = FDC_RAMP_BASE_NS / FDC_CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    FDC_ST_IDLE = 5'b00001,
    FDC_ST_RX   = 5'b00010,
    FDC_ST_ACK  = 5'b00100,
    FDC_ST_TX   = 5'b01000,
    FDC_ST_RACK = 5'b10000
  } fdc_state_type;

  typedef enum logic [2:0] {
    FDC_BYTE_ADDR = 3'b001,
    FDC_BYTE_CMD  = 3'b010,
    FDC_BYTE_DATA = 3'b100
  } fdc_byte_type;

endpackage

// [logic/fdc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fdc_top #(
  parameter int RAMP_BASE_CYCLES = fdc_pkg::FDC_RAMP_BASE_CYC
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_N_O,
  input  wire logic [7:0] LOCAL_TEMP_I,
  input  wire logic [7:0] REMOTE_TEMP_I,
  output logic            PWM_O
);

  // Pin synchronisers; the first stage feeds only the second.
  logic       scl_m_q, scl_s_q, scl_d_q;
  logic       sda_m_q, sda_s_q, sda_d_q;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_d_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_m_q <= SCL_I;
      scl_s_q <= scl_m_q;
      scl_d_q <= scl_s_q;
      sda_m_q <= SDA_I;
      sda_s_q <= sda_m_q;
      sda_d_q <= sda_s_q;
    end
  end

  // Bus events seen on the synchronised lines.
  wire scl_rise = scl_s_q & ~scl_d_q;
  wire scl_fall = ~scl_s_q & scl_d_q;
  wire bus_start = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
  wire bus_stop  = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;

  fdc_pkg::fdc_state_type state_q;
  fdc_pkg::fdc_byte_type  kind_q;
  logic [7:0] rx_sh_q, tx_sh_q, ptr_q;
  logic [3:0] bit_cnt_q;
  logic       rd_q, sda_oe_n_q;

  // Registers of the block.
  logic [7:0] config_q, hold_q, low_duty_q, ramp_q, local_q, remote_q;
  logic [7:0] auto_q, pwm_cnt_q;
  logic       pwm_q;
  logic [23:0] tick_cnt_q;

  // Byte completion and the resulting register write.
  wire byte_done = (state_q == fdc_pkg::FDC_ST_RX) & scl_fall & (bit_cnt_q == fdc_pkg::FDC_BITS_BYTE);
  wire addr_hit  = rx_sh_q[7:1] == fdc_pkg::FDC_DEV_ADDR;
  wire wr_en     = byte_done & (kind_q == fdc_pkg::FDC_BYTE_DATA);
  wire wr_config = wr_en & (ptr_q == fdc_pkg::FDC_OFS_CONFIG);
  wire wr_low    = wr_en & (ptr_q == fdc_pkg::FDC_OFS_LOW_DUTY);
  wire wr_duty   = wr_en & (ptr_q == fdc_pkg::FDC_OFS_DUTY);
  wire wr_ramp   = wr_en & (ptr_q == fdc_pkg::FDC_OFS_RAMP);
  wire wr_local  = wr_en & (ptr_q == fdc_pkg::FDC_OFS_LOCAL);
  wire wr_remote = wr_en & (ptr_q == fdc_pkg::FDC_OFS_REMOTE);

  // Duty selection: direct mode reads the holding store, so a write there shows at once.
  wire [1:0] mode       = config_q[fdc_pkg::FDC_MODE_LSB +: 2];
  wire       direct     = mode == fdc_pkg::FDC_MODE_DIRECT;
  wire [7:0] duty_value = direct ? hold_q : auto_q;  // see RULE2 see RULE4 see RULE6

  // Read mux; the duty offset returns the live duty, not the stored write.
  wire [7:0] rd_data =
    (ptr_q == fdc_pkg::FDC_OFS_CONFIG)   ? config_q   :
    (ptr_q == fdc_pkg::FDC_OFS_LOW_DUTY) ? low_duty_q :
    (ptr_q == fdc_pkg::FDC_OFS_DUTY)     ? duty_value :  // see RULE3
    (ptr_q == fdc_pkg::FDC_OFS_RAMP)     ? ramp_q     :
    (ptr_q == fdc_pkg::FDC_OFS_LOCAL)    ? local_q    :
    (ptr_q == fdc_pkg::FDC_OFS_REMOTE)   ? remote_q   : fdc_pkg::FDC_READ_UNMAPPED;

  // Open-drain drive: low during an acknowledge or a zero data bit.
  wire sda_drive = (state_q == fdc_pkg::FDC_ST_ACK) |
                   ((state_q == fdc_pkg::FDC_ST_TX) & ~tx_sh_q[7]);

  // Serial slave sequencer: address, register pointer, then data bytes.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_q    <= fdc_pkg::FDC_ST_IDLE;
      kind_q     <= fdc_pkg::FDC_BYTE_ADDR;
      rx_sh_q    <= 8'h00;
      tx_sh_q    <= 8'h00;
      ptr_q      <= 8'h00;
      bit_cnt_q  <= 4'h0;
      rd_q       <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else begin
      sda_oe_n_q <= ~sda_drive;
      if (bus_start) begin
        state_q   <= fdc_pkg::FDC_ST_RX;
        kind_q    <= fdc_pkg::FDC_BYTE_ADDR;
        bit_cnt_q <= 4'h0;
      end else if (bus_stop) begin
        state_q <= fdc_pkg::FDC_ST_IDLE;
      end else begin
        case (state_q)
          fdc_pkg::FDC_ST_IDLE: begin
            bit_cnt_q <= 4'h0;
          end
          fdc_pkg::FDC_ST_RX: begin
            if (scl_rise && bit_cnt_q != fdc_pkg::FDC_BITS_BYTE) begin
              rx_sh_q   <= {rx_sh_q[6:0], sda_s_q};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (byte_done) begin
              bit_cnt_q <= 4'h0;
              state_q   <= fdc_pkg::FDC_ST_ACK;
              if (kind_q == fdc_pkg::FDC_BYTE_ADDR) begin
                rd_q <= rx_sh_q[0];
                if (!addr_hit) begin
                  state_q <= fdc_pkg::FDC_ST_IDLE;  // Not ours: stay off the bus.
                end
              end else if (kind_q == fdc_pkg::FDC_BYTE_CMD) begin
                ptr_q <= rx_sh_q;
              end
            end
          end
          fdc_pkg::FDC_ST_ACK: begin
            if (scl_fall) begin
              if (kind_q == fdc_pkg::FDC_BYTE_ADDR && rd_q) begin
                state_q <= fdc_pkg::FDC_ST_TX;
                tx_sh_q <= rd_data;
              end else begin
                state_q <= fdc_pkg::FDC_ST_RX;
                kind_q  <= (kind_q == fdc_pkg::FDC_BYTE_ADDR) ? fdc_pkg::FDC_BYTE_CMD : fdc_pkg::FDC_BYTE_DATA;
              end
            end
          end
          fdc_pkg::FDC_ST_TX: begin
            if (scl_fall) begin
              tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
              if (bit_cnt_q == fdc_pkg::FDC_BIT_LAST) begin
                state_q   <= fdc_pkg::FDC_ST_RACK;
                bit_cnt_q <= 4'h0;
              end
            end
          end
          fdc_pkg::FDC_ST_RACK: begin
            // A master that does not acknowledge ends the read.
            if (scl_rise && sda_s_q) begin
              state_q <= fdc_pkg::FDC_ST_IDLE;
            end else if (scl_fall) begin
              state_q <= fdc_pkg::FDC_ST_TX;
              tx_sh_q <= rd_data;
            end
          end
          default: begin
            state_q <= fdc_pkg::FDC_ST_IDLE;
          end
        endcase
      end
    end
  end

  // Software registers; the holding store takes every duty write in any mode.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      config_q   <= fdc_pkg::FDC_RST_CONFIG;
      hold_q     <= fdc_pkg::FDC_RST_DUTY;  // see RULE11 see RULE1
      low_duty_q <= fdc_pkg::FDC_RST_LOW_DUTY;  // see RULE10
      ramp_q     <= fdc_pkg::FDC_RST_RAMP;  // see RULE7
      local_q    <= fdc_pkg::FDC_RST_LOCAL;  // see RULE8
      remote_q   <= fdc_pkg::FDC_RST_REMOTE;  // see RULE9
    end else begin
      if (wr_config) config_q <= rx_sh_q;
      if (wr_duty) hold_q <= rx_sh_q;  // see RULE5
      if (wr_low) low_duty_q <= rx_sh_q;
      if (wr_ramp) ramp_q <= rx_sh_q;
      if (wr_local) local_q <= rx_sh_q;
      if (wr_remote) remote_q <= rx_sh_q;
    end
  end

  // Temperature to duty mapping: low-temperature duty at or below the point, then
  // a rise of 2^slope counts per degree, saturating at full on.
  function automatic logic [7:0] fdc_map(input logic [7:0] temp, input logic [7:0] map,
                                         input logic [7:0] base);
    logic [7:0]  point;
    logic [7:0]  over;
    logic [15:0] sum;
    point = {map[fdc_pkg::FDC_PT_LSB +: 5], 3'h0} >> 1;
    over  = temp - point;
    sum   = {8'h00, base} + ({8'h00, over} << map[fdc_pkg::FDC_SLOPE_LSB +: 3]);
    if (temp <= point) begin
      fdc_map = base;  // see RULE10
    end else if (sum > {8'h00, fdc_pkg::FDC_DUTY_MAX}) begin
      fdc_map = fdc_pkg::FDC_DUTY_MAX;
    end else begin
      fdc_map = sum[7:0];
    end
  endfunction

  wire [7:0] loc_tgt = fdc_map(LOCAL_TEMP_I, local_q, low_duty_q);
  wire [7:0] rem_tgt = fdc_map(REMOTE_TEMP_I, remote_q, low_duty_q);
  wire [7:0] target  = (loc_tgt > rem_tgt) ? loc_tgt : rem_tgt;

  // Ramp pacing: the step size and interval come from the ramp register.
  wire        ramp_on   = ramp_q[fdc_pkg::FDC_RAMP_ON];
  wire [7:0]  step_size = 8'h01 << ramp_q[fdc_pkg::FDC_STEP_LSB +: 2];
  wire [23:0] tick_lim  = 24'(RAMP_BASE_CYCLES) << ramp_q[fdc_pkg::FDC_RATE_LSB +: 3];
  wire        tick      = tick_cnt_q >= tick_lim - 24'h1;
  wire [8:0]  up_sum    = {1'b0, auto_q} + {1'b0, step_size};
  wire [7:0]  ramp_up   = (up_sum[7:0] > target || up_sum[8]) ? target : up_sum[7:0];
  // The compare is one bit wider so a target near full on cannot wrap and let the step undershoot.
  wire [7:0]  ramp_dn   = ({1'b0, auto_q} < {1'b0, target} + {1'b0, step_size}) ? target : auto_q - step_size;

  // Automatic duty; the speed-loop mode simply holds the last value here.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      auto_q     <= fdc_pkg::FDC_RST_DUTY;
      tick_cnt_q <= 24'h000000;
    end else begin
      tick_cnt_q <= tick ? 24'h000000 : tick_cnt_q + 24'h000001;
      if (mode == fdc_pkg::FDC_MODE_AUTO) begin
        if (!ramp_on) begin
          auto_q <= target;
        end else if (tick) begin
          auto_q <= (auto_q < target) ? ramp_up : ramp_dn;
        end
      end else if (direct) begin
        auto_q <= hold_q;  // Leaving direct mode starts from the duty in force.
      end
    end
  end

  // Pulse-width output over a 255-count period; 0x00 is off, 0xff is fully on.
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pwm_cnt_q <= 8'h00;
      pwm_q     <= 1'b0;
    end else begin
      pwm_cnt_q <= (pwm_cnt_q == fdc_pkg::FDC_PWM_LAST) ? 8'h00 : pwm_cnt_q + 8'h01;
      pwm_q     <= pwm_cnt_q < duty_value;  // see RULE1 see RULE2
    end
  end

  assign PWM_O      = pwm_q;
  assign SDA_O      = 1'b0;
  assign SDA_OE_N_O = sda_oe_n_q;

endmodule // fdc_top
`default_nettype wire

// [verification/fdc_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the serial pins and the fan output of the duty control block.
module fdc_assertions #(
  parameter int RAMP_BASE_CYCLES = 4
) (
  input wire logic       CLK_I,
  input wire logic       RST_N_I,
  input wire logic       SCL_I,
  input wire logic       SDA_I,
  input wire logic       SDA_O,
  input wire logic       SDA_OE_N_O,
  input wire logic [7:0] LOCAL_TEMP_I,
  input wire logic [7:0] REMOTE_TEMP_I,
  input wire logic       PWM_O
);
  logic        scl_q;
  logic        pwm_q;
  logic        seen_q;
  logic [7:0]  since_q;
  logic [7:0]  quiet_q;
  logic [15:0] temp_q;
  logic [31:0] gap_q;
  wire         duty_event = (scl_q & ~SCL_I) | (temp_q != {LOCAL_TEMP_I, REMOTE_TEMP_I});

  default clocking cb @(posedge CLK_I); endclocking

  // Cycles since the last serial clock fall and since the last fan output rise.
  // A duty change may raise the output mid-period just after a bus clock fall or a temperature change,
  // so only a rise well clear of such events counts as a period start; automatic ramping is not covered.
  always_ff @(posedge CLK_I) begin
    scl_q  <= SCL_I;
    pwm_q  <= PWM_O;
    temp_q <= {LOCAL_TEMP_I, REMOTE_TEMP_I};
    if (!RST_N_I) begin
      since_q <= 8'hff;
      quiet_q <= 8'h00;
      seen_q  <= 1'b0;
      gap_q   <= 32'h0;
    end else begin
      since_q <= (scl_q & ~SCL_I) ? 8'h00 : ((since_q == 8'hff) ? since_q : since_q + 8'h01);
      quiet_q <= duty_event ? 8'h00 : ((quiet_q == 8'hff) ? quiet_q : quiet_q + 8'h01);
      seen_q  <= (quiet_q < 8'h10) ? 1'b0 : (seen_q | (PWM_O & ~pwm_q));
      gap_q   <= (PWM_O & ~pwm_q) ? 32'h1 : gap_q + 32'h1;
    end
  end

  a_reset_sda_idle: assert property (!RST_N_I |=> SDA_OE_N_O)
    else $error("serial data pulled during reset");
  a_sda_only_low: assert property (disable iff (!RST_N_I) !SDA_OE_N_O |-> !SDA_O)
    else $error("serial data driven high");
  a_change_after_fall: assert property (disable iff (!RST_N_I) $changed(SDA_OE_N_O) |-> since_q <= 8'h08)
    else $error("serial data moved far from a clock fall");
  a_sda_stable_high: assert property (disable iff (!RST_N_I)
    SCL_I && $past(SCL_I) && $past(SCL_I, 2) && $past(SCL_I, 3) |-> $stable(SDA_OE_N_O))
    else $error("serial data moved while clock high");
  a_pull_scl_low: assert property (disable iff (!RST_N_I) $fell(SDA_OE_N_O) |-> !SCL_I)
    else $error("serial data pulled while clock high");
  a_reset_pwm_low: assert property (!RST_N_I |=> !PWM_O)
    else $error("fan output high during reset");
  a_pwm_starts_soon: assert property (disable iff (!RST_N_I) $rose(RST_N_I) |-> ##[1:3] PWM_O)
    else $error("default duty not on fan output");
  a_pwm_period_fixed: assert property (disable iff (!RST_N_I)
    PWM_O && !pwm_q && seen_q |-> (gap_q % 255) == 0)
    else $error("fan output period broken");
endmodule // fdc_assertions

bind fdc_top fdc_assertions #(.RAMP_BASE_CYCLES(RAMP_BASE_CYCLES)) chk_u (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE_N_O(SDA_OE_N_O), .LOCAL_TEMP_I(LOCAL_TEMP_I), .REMOTE_TEMP_I(REMOTE_TEMP_I), .PWM_O(PWM_O));
`default_nettype wire

// [verification/fdc_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module fdc_tb_top;
  logic       clk;
  logic       rst_n;
  logic       scl;
  logic       sda_m;
  logic       sda_o;
  logic       sda_oe_n;
  logic       pwm;
  logic [7:0] local_temp;
  logic [7:0] remote_temp;
  wire        sda_line;
  int         error_cnt;
  int         check_count;

  // Open-drain data line: master and device can only pull it low.
  assign sda_line = sda_m & (sda_oe_n | sda_o);

  fdc_top #(.RAMP_BASE_CYCLES(4)) dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda_line), .SDA_O(sda_o),
    .SDA_OE_N_O(sda_oe_n), .LOCAL_TEMP_I(local_temp), .REMOTE_TEMP_I(remote_temp), .PWM_O(pwm));

  // Free running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Inputs always move 1 ns after a rising edge, clear of sampling.
  task automatic clk_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] ev);
    check_count++;
    if (seen !== ev) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, ev, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Bus bits are slow next to the clock so the input synchronisers keep up.
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    clk_n(5);
    scl = 1'b1;
    clk_n(5);
    r = sda_line;
    clk_n(5);
    scl = 1'b0;
    clk_n(5);
  endtask

  task automatic byte_x(input logic [7:0] w, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
    bit_x(1'b1, ack);
  endtask

  task automatic start_c();
    sda_m = 1'b1;
    clk_n(5);
    scl = 1'b1;
    clk_n(10);
    sda_m = 1'b0;
    clk_n(10);
    scl = 1'b0;
    clk_n(5);
  endtask

  task automatic stop_c();
    sda_m = 1'b0;
    clk_n(5);
    scl = 1'b1;
    clk_n(10);
    sda_m = 1'b1;
    clk_n(10);
  endtask

  // Pointer then data, each byte acknowledged by the device.
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] r;
    logic       a0, a1, a2;
    start_c();
    byte_x({fdc_pkg::FDC_DEV_ADDR, 1'b0}, r, a0);
    byte_x(ofs, r, a1);
    byte_x(d, r, a2);
    stop_c();
    check("write ack", {7'h00, a0 | a1 | a2}, 8'h00);
  endtask

  // Pointer write, repeated start, one byte read and closed by a not-acknowledge.
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] r;
    logic       a0, a1, a2, a3;
    start_c();
    byte_x({fdc_pkg::FDC_DEV_ADDR, 1'b0}, r, a0);
    byte_x(ofs, r, a1);
    start_c();
    byte_x({fdc_pkg::FDC_DEV_ADDR, 1'b1}, r, a2);
    byte_x(8'hff, d, a3);
    stop_c();
    check("read ack", {7'h00, a0 | a1 | a2}, 8'h00);
  endtask

  // Any 255-cycle window holds exactly duty high cycles.
  task automatic measure(output logic [7:0] d);
    int n;
    n = 0;
    clk_n(10);
    repeat (255) begin
      if (pwm === 1'b1) n++;
      clk_n(1);
    end
    d = n[7:0];
  endtask

  task automatic test_reset_values();
    logic [7:0] ofs [6] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h30};
    logic [7:0] ev [6] = '{8'h55, 8'h55, 8'h52, 8'h41, 8'h61, 8'h00};
    logic [7:0] r;
    for (int i = 0; i < 6; i++) begin
      read_reg(ofs[i], r);
      check("reset value", r, ev[i]);
    end
    measure(r);
    check("default duty", r, 8'h55);
  endtask

  // Temperatures at, just above and well above the low-temperature points.
  task automatic test_temp_map();
    logic [7:0] r;
    local_temp = 8'h20;
    measure(r);
    check("at low point", r, 8'h55);
    local_temp = 8'h21;
    measure(r);
    check("local slope", r, 8'h57);
    remote_temp = 8'h38;
    measure(r);
    check("remote slope", r, 8'h65);
    local_temp = 8'h14;
    remote_temp = 8'h00;
    measure(r);
    check("back to low duty", r, 8'h55);
  endtask

  // Speed-loop mode keeps the duty in force and parks duty writes in the store.
  task automatic test_hold_mode();
    logic [7:0] r;
    write_reg(8'h00, {6'h00, fdc_pkg::FDC_MODE_RPM});
    measure(r);
    check("hold mode duty", r, 8'h55);
    write_reg(8'h22, 8'h77);
    measure(r);
    check("hold mode write", r, 8'h55);
    read_reg(8'h22, r);
    check("hold mode read", r, 8'h55);
    write_reg(8'h00, {6'h00, fdc_pkg::FDC_MODE_DIRECT});
    measure(r);
    check("store to direct", r, 8'h77);
  endtask

  task automatic test_auto_hold();
    logic [7:0] r;
    write_reg(8'h22, 8'h10);
    measure(r);
    check("auto duty kept", r, 8'h55);
    write_reg(8'h21, 8'h30);
    measure(r);
    check("low temp duty", r, 8'h30);
    read_reg(8'h22, r);
    check("live duty read", r, 8'h30);
    write_reg(8'h00, {6'h00, fdc_pkg::FDC_MODE_DIRECT});
    measure(r);
    check("store applied", r, 8'h10);
    read_reg(8'h22, r);
    check("direct duty read", r, 8'h10);
  endtask

  // Both ends of the range and values between, each measured and read back after its write.
  task automatic test_direct_writes();
    logic [7:0] v [4] = '{8'h00, 8'hc8, 8'hff, 8'h01};
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      write_reg(8'h22, v[i]);
      measure(r);
      check("direct duty", r, v[i]);
      read_reg(8'h22, r);
      check("duty read", r, v[i]);
    end
  endtask

  task automatic test_rw_regs();
    logic [7:0] ofs [3] = '{8'h23, 8'h24, 8'h25};
    logic [7:0] v [3] = '{8'ha4, 8'h5b, 8'h3c};
    logic [7:0] r;
    for (int i = 0; i < 3; i++) begin
      write_reg(ofs[i], v[i]);
      read_reg(ofs[i], r);
      check("register write", r, v[i]);
    end
  endtask

  // A mid-run reset, then direct mode with no duty write at all.
  task automatic test_reset_store();
    logic [7:0] r;
    rst_n = 1'b0;
    clk_n(8);
    rst_n = 1'b1;
    clk_n(5);
    write_reg(8'h00, {6'h00, fdc_pkg::FDC_MODE_DIRECT});
    measure(r);
    check("store reset duty", r, 8'h55);
  endtask

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    scl = 1'b1;
    sda_m = 1'b1;
    local_temp = 8'h14;
    remote_temp = 8'h00;
    error_cnt = 0;
    check_count = 0;
    clk_n(8);
    rst_n = 1'b1;
    clk_n(5);
    test_reset_values();
    test_temp_map();
    test_auto_hold();
    test_direct_writes();
    test_rw_regs();
    test_reset_store();
    test_hold_mode();
    end_sim();
  end

  // The whole run needs about 25500 cycles; over three times that means a hang.
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule // fdc_tb_top
`default_nettype wire
